// *** verilog/tsb_cfg.svh ***
`ifndef TSB_CFG_SVH
`define TSB_CFG_SVH
// Register byte addresses (preprocessor config index Eh times four)
`define TSB_IDX_PRECFG 4'hE
`define TSB_ADDR_PRECFG 8'h38
`define TSB_ADDR_BATCH 8'h00
`define TSB_ADDR_SCAN 8'h04
`define TSB_ADDR_STATUS 8'h08
// Reset values
`define TSB_RST_PRECFG 16'h0000
`define TSB_RST_BATCH 3'h0
// Writable bits of preprocessor config: D15..D10, D4..D1
`define TSB_PRECFG_WMASK 16'hFC1E
`define TSB_PRECFG_WMASK_LO 8'h1E
`define TSB_PRECFG_WMASK_HI 8'hFC
// Scan control bits
`define TSB_SCAN_START_BIT 0
`define TSB_SCAN_STOP_BIT 1
// Timing
`define TSB_CLK_HZ 20000000
`define TSB_TICK_MS 1
`define TSB_TICK_CYC ((`TSB_CLK_HZ / 1000) * `TSB_TICK_MS)
`define TSB_D1_MS 7'h01
`define TSB_D2_MS 7'h02
`define TSB_D3_MS 7'h04
`define TSB_D4_MS 7'h0A
`define TSB_D5_MS 7'h14
`define TSB_D6_MS 7'h28
`define TSB_D7_MS 7'h64
`endif

// *** verilog/tsb_pkg.sv ***
package tsb_pkg;
  typedef enum logic [1:0] {
    TSB_IDLE,
    TSB_CONVERT,
    TSB_WAIT
  } tsb_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } tsb_wreq_t;

  typedef struct packed {
    logic [2:0] batch_delay_select;
    logic [15:0] preprocessor_config;
  } tsb_cfg_t;
endpackage : tsb_pkg

// *** verilog/tsb_batch_delay.sv ***
// What this block does
// - Selector zero inserts no delay; throughput set by conversion timing only.
// - Codes 001..111 give 1,2,4,10,20,40,100 ms delays.
// - After first set, wait idle until selected delay fully expires.
// - Starting next set on persistent touch restarts delay from full value.
// - Repeat paced sets until touch gone, stop command, or reset.
// - 16-bit preprocessor config at index Eh, resets to 0000h.
// - Delay timer starts when a touch starts the conversion scan.
// - If conversion time exceeds delay, conversion time sets the pace.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "tsb_cfg.svh"
module tsb_batch_delay
  import tsb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pen_touch,
  input wire logic set_done,
  output logic set_start,
  output logic scan_active
);

  // Pin synchroniser: first stage read only by second
  logic touch_s1_reg;
  logic touch_s2_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      touch_s1_reg <= 1'b0;
      touch_s2_reg <= 1'b0;
    end else begin
      touch_s1_reg <= pen_touch;
      touch_s2_reg <= touch_s1_reg;
    end
  end

  // Write channel state
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  tsb_wreq_t wreq_reg, wreq_next;
  logic [3:0] wstrb_reg, wstrb_next;
  tsb_cfg_t cfg_reg, cfg_next;
  logic start_cmd, stop_cmd;
  logic do_write;

  // Registers
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    wreq_next = wreq_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    cfg_next = cfg_reg;
    start_cmd = 1'b0;
    stop_cmd = 1'b0;
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      wreq_next.addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wreq_next.data = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = 2'h0;
      case (wreq_reg.addr)
        `TSB_ADDR_BATCH: begin
          if (wstrb_reg[0]) begin
            cfg_next.batch_delay_select = wreq_reg.data[2:0];
          end
        end
        `TSB_ADDR_PRECFG: begin
          // Per-lane masks keep reserved bits at zero
          // Byte masks sized to the lane, no silent truncation
          if (wstrb_reg[0]) begin
            cfg_next.preprocessor_config[7:0] =
              wreq_reg.data[7:0] & `TSB_PRECFG_WMASK_LO;
          end
          if (wstrb_reg[1]) begin
            cfg_next.preprocessor_config[15:8] =
              wreq_reg.data[15:8] & `TSB_PRECFG_WMASK_HI;
          end
        end
        `TSB_ADDR_SCAN: begin
          if (wstrb_reg[0]) begin
            start_cmd = wreq_reg.data[`TSB_SCAN_START_BIT];
            stop_cmd = wreq_reg.data[`TSB_SCAN_STOP_BIT];
          end
        end
        `TSB_ADDR_STATUS: begin
          bresp_next = 2'h0;
        end
        default: begin
          bresp_next = 2'h2;
        end
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wreq_reg <= '0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      cfg_reg.batch_delay_select <= `TSB_RST_BATCH;
      cfg_reg.preprocessor_config <= `TSB_RST_PRECFG;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      wreq_reg <= wreq_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      cfg_reg <= cfg_next;
    end
  end

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Scan sequencer and millisecond timer
  tsb_state_t state_reg, state_next;
  logic [14:0] tick_cnt_reg, tick_cnt_next;
  logic [6:0] ms_cnt_reg, ms_cnt_next;
  logic set_busy_reg, set_busy_next;
  logic start_pend_reg, start_pend_next;
  logic [6:0] delay_ms;
  logic delay_done;

  // Delay lookup from selector code
  always_comb begin
    case (cfg_reg.batch_delay_select)
      3'h1: delay_ms = `TSB_D1_MS;
      3'h2: delay_ms = `TSB_D2_MS;
      3'h3: delay_ms = `TSB_D3_MS;
      3'h4: delay_ms = `TSB_D4_MS;
      3'h5: delay_ms = `TSB_D5_MS;
      3'h6: delay_ms = `TSB_D6_MS;
      3'h7: delay_ms = `TSB_D7_MS;
      default: delay_ms = 7'h00;
    endcase
  end

  // Live selector: a change mid-delay applies at once
  assign delay_done = (ms_cnt_reg >= delay_ms);

  always_comb begin
    state_next = state_reg;
    tick_cnt_next = tick_cnt_reg;
    ms_cnt_next = ms_cnt_reg;
    set_busy_next = set_busy_reg;
    start_pend_next = start_pend_reg || start_cmd;
    set_start = 1'b0;
    // Millisecond tick, saturating so a long set cannot wrap
    if (tick_cnt_reg == 15'(`TSB_TICK_CYC - 1)) begin
      tick_cnt_next = 15'h0000;
      if (ms_cnt_reg != 7'h7F) begin
        ms_cnt_next = ms_cnt_reg + 7'h01;
      end
    end else begin
      tick_cnt_next = tick_cnt_reg + 15'h0001;
    end
    if (set_done) begin
      set_busy_next = 1'b0;
    end
    case (state_reg)
      TSB_IDLE: begin
        if (touch_s2_reg && start_pend_reg && !stop_cmd) begin
          state_next = TSB_CONVERT;
          set_start = 1'b1;
          set_busy_next = 1'b1;
          start_pend_next = 1'b0;
          tick_cnt_next = 15'h0000;
          ms_cnt_next = 7'h00;
        end
      end
      TSB_CONVERT: begin
        // Conversion time dominates when longer than delay
        if (set_done || !set_busy_reg) begin
          state_next = TSB_WAIT;
        end
      end
      TSB_WAIT: begin
        if (delay_done && touch_s2_reg) begin
          state_next = TSB_CONVERT;
          set_start = 1'b1;
          set_busy_next = 1'b1;
          tick_cnt_next = 15'h0000;
          ms_cnt_next = 7'h00;
        end
      end
      default: begin
        state_next = TSB_IDLE;
      end
    endcase
    // Touch loss or stop ends the scan
    if (state_reg != TSB_IDLE && (stop_cmd || !touch_s2_reg)) begin
      state_next = TSB_IDLE;
      set_start = 1'b0;
      set_busy_next = 1'b0;
      start_pend_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= TSB_IDLE;
      tick_cnt_reg <= 15'h0000;
      ms_cnt_reg <= 7'h00;
      set_busy_reg <= 1'b0;
      start_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      ms_cnt_reg <= ms_cnt_next;
      set_busy_reg <= set_busy_next;
      start_pend_reg <= start_pend_next;
    end
  end

  assign scan_active = (state_reg != TSB_IDLE);

  // Read channel; data registered at address acceptance
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      case (s_axi_araddr[7:0])
        `TSB_ADDR_BATCH: rdata_next = {29'h0, cfg_reg.batch_delay_select};
        `TSB_ADDR_PRECFG: rdata_next = {16'h0, cfg_reg.preprocessor_config};
        `TSB_ADDR_SCAN: rdata_next = 32'h0000_0000;
        `TSB_ADDR_STATUS: begin
          rdata_next = {16'h0, 1'b0, ms_cnt_reg, 4'h0,
            start_pend_reg, touch_s2_reg, set_busy_reg, scan_active};
        end
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = 2'h2;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule : tsb_batch_delay

// *** verif/tsb_batch_delay_sva.sv ***
`timescale 1ns/10ps
module tsb_batch_delay_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pen_touch,
  input wire logic set_start,
  input wire logic scan_active,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Scan start and touch sync relations
  property p_start_pulse;
    set_start |=> !set_start && scan_active;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("bad start");
  property p_start_touch;
    set_start |-> $past(pen_touch, 2);
  endproperty
  a_start_touch: assert property (p_start_touch) else $error("no touch");
  property p_touch_loss;
    !pen_touch [*4] |-> !scan_active;
  endproperty
  a_touch_loss: assert property (p_touch_loss) else $error("no stop");
  property p_rise;
    $rose(scan_active) |-> $past(set_start);
  endproperty
  a_rise: assert property (p_rise) else $error("scan w/o start");
  // Answers hold until the master takes them; reads accepted only when idle, answered next cycle
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("b dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("r dropped");
  property p_arready;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_arready: assert property (p_arready) else $error("arready");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read late");
  c_start: cover property (set_start);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_drop: cover property ($fell(scan_active));
endmodule : tsb_batch_delay_sva
bind tsb_batch_delay tsb_batch_delay_sva i_sva (.aclk, .aresetn, .pen_touch,
  .set_start, .scan_active, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// *** verif/tsb_conv_model.sv ***
`timescale 1ns/10ps
module tsb_conv_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set_start,
  input wire logic [31:0] lat,
  output logic set_done
);
  logic [31:0] cnt;
  // Countdown per set; a new start reloads it, as a real converter would
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt <= 32'h0;
    else cnt <= set_start ? lat : (cnt != 0 ? cnt - 1 : 32'h0);
    set_done <= aresetn && cnt == 32'h1;
  end
endmodule : tsb_conv_model

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
`include "tsb_cfg.svh"
module tb_top;
  import tsb_pkg::*;
  localparam int LIM = 99999;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pen_touch = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [31:0] lat = 32'h32;
  logic set_done, set_start, scan_active;
  int fails = 0, compares = 0;
  // Register model: mapped offsets and their writable bits
  int msk [int] = '{0: 7, 4: 0, 56: `TSB_PRECFG_WMASK};
  int shadow [int];
  tsb_batch_delay i_tsb_batch_delay (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pen_touch, .set_done, .set_start, .scan_active);
  tsb_conv_model i_tsb_conv_model (.aclk, .aresetn, .set_start, .lat,
    .set_done);
  initial forever #25 aclk = ~aclk;
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic tmo(input bit over);
    if (over) begin
      fails++;
      $display("[FAIL] wait exp answer got none");
      summarize();
    end
  endtask : tmo
  task automatic chk_word(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk_word
  task automatic chk_gap(input string n, input int lo, hi, g);
    compares++;
    if (g < lo || g > hi) begin
      fails++;
      $display("[FAIL] %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask : chk_gap
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic aw_ok, w_ok, b_ok;
    logic [1:0] resp;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < LIM; i++) begin
      // Sample settled outputs mid-cycle; act right after the next edge
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      if (b_ok) break;
    end
    tmo(i == LIM);
    s_axi_bready <= 1'b0;
    if (msk.exists(a)) shadow[a] = d & msk[a];
    chk_word("bresp", msk.exists(a) ? 0 : 2, resp);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a);
    int i;
    logic ar_ok, r_ok;
    logic [1:0] resp;
    logic [31:0] data;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < LIM; i++) begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      resp = s_axi_rresp;
      data = s_axi_rdata;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      if (r_ok) break;
    end
    tmo(i == LIM);
    s_axi_rready <= 1'b0;
    chk_word("rresp", msk.exists(a) ? 0 : 2, resp);
    chk_word("rdata", shadow.exists(a) ? shadow[a] : 0, data);
  endtask : rd_chk
  // Cycles between two set starts, sampled mid-cycle to avoid edge races
  task automatic gap_chk(input int lo, hi);
    int i;
    int n;
    @(negedge aclk);
    for (i = 0; i < LIM && !set_start; i++) @(negedge aclk);
    tmo(i == LIM);
    @(negedge aclk);
    for (n = 1; n < LIM && !set_start; n++) @(negedge aclk);
    tmo(n == LIM);
    chk_gap("set gap", lo, hi, n);
  endtask : gap_chk
  initial begin
    int i;
    void'($urandom(88485));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h38);
    rd_chk(8'h00);
    wr(8'h38, $urandom());
    rd_chk(8'h38);
    wr(8'h3C, $urandom());
    rd_chk(8'h3C);
    pen_touch <= 1'b1;
    wr(8'h04, 32'h1);
    gap_chk(50, 53);
    wr(8'h00, 32'h1);
    gap_chk(20000, 20003);
    lat <= 32'h0000_5208;
    gap_chk(21000, 21003);
    // Stop command, then a new scan cut short by touch loss
    wr(8'h04, 32'h2);
    repeat (3) @(negedge aclk);
    chk_word("scan_active", 0, scan_active);
    wr(8'h04, 32'h1);
    for (i = 0; i < LIM && !scan_active; i++) @(negedge aclk);
    tmo(i == LIM);
    @(posedge aclk);
    pen_touch <= 1'b0;
    repeat (6) @(negedge aclk);
    chk_word("scan_active", 0, scan_active);
    // Reset in mid-scan halts it and restores register defaults
    @(posedge aclk);
    pen_touch <= 1'b1;
    wr(8'h04, 32'h1);
    for (i = 0; i < LIM && !scan_active; i++) @(negedge aclk);
    tmo(i == LIM);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    shadow.delete();
    @(negedge aclk);
    chk_word("scan_active", 0, scan_active);
    rd_chk(8'h38);
    rd_chk(8'h00);
    summarize();
  end
endmodule : tb_top
